// File: adc_xram_dma.sv
// Module: ADC-to-XRAM DMA control, status and double buffering
`timescale 1ns/1ps
module adc_xram_dma #(
    parameter int DATA_W = 16,
    parameter int FIFO_D = dma_pkg::FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic [5:0]        instr_boundary,
    input  wire logic [15:0]       xram_base,
    input  wire logic [15:0]       repeat_limit,
    input  wire logic              adc0_done,
    input  wire logic [DATA_W-1:0] adc0_data,
    input  wire logic              adc1_done,
    input  wire logic [DATA_W-1:0] adc1_data,
    input  wire logic              diff_mode,
    input  wire logic              xram_offchip,
    input  wire logic              xram_grant,
    output logic                   xram_wr,
    output logic      [15:0]       xram_addr,
    output logic      [DATA_W-1:0] xram_wdata,
    output logic                   dma_irq
);
    logic [7:0]        ctl_reg;
    logic [7:0]        cfg_reg;
    logic [5:0]        iaddr_reg;
    logic [7:0]        ibuf [dma_pkg::INSTR_DEPTH];
    logic [DATA_W-1:0] buf0_reg;
    logic [DATA_W-1:0] buf1_reg;
    logic              full0_reg;
    logic              full1_reg;
    logic              pend0_reg;
    logic              pend1_reg;
    logic [DATA_W-1:0] hold0_reg;
    logic [DATA_W-1:0] hold1_reg;
    logic [15:0]       wptr_reg;
    logic [15:0]       rep_reg;
    logic [5:0]        pc_reg;
    logic [7:0]        ins_reg;
    logic              need0_reg;
    logic              need1_reg;
    dma_pkg::seq_state_t state_reg;
    logic              wr_ctl;
    logic              wr_cfg;
    logic              acc_idt;
    logic              ff_in_valid;
    logic              ff_in_ready;
    logic [DATA_W-1:0] ff_in_data;
    logic              ff_out_valid;
    logic              ff_out_ready;
    logic [DATA_W-1:0] ff_out_data;
    logic              bus_ok;
    logic              take0;
    logic              take1;
    logic              ev_done;
    logic              ev_eop;
    logic              ev_rep;
    logic              ev_warn0;
    logic              ev_warn1;
    logic              ev_err0;
    logic              ev_err1;
    logic              instr_end;
    logic              running;

    function automatic logic is_eop(input logic [7:0] w);
        is_eop = !(w[dma_pkg::INS_DIFF] | w[dma_pkg::INS_ADC1] | w[dma_pkg::INS_ADC0]);
    endfunction

    assign wr_ctl  = reg_wr && (reg_addr == dma_pkg::ADDR_CONTROL);
    assign wr_cfg  = reg_wr && (reg_addr == dma_pkg::ADDR_CONFIG);
    assign acc_idt = (reg_wr || reg_rd) && (reg_addr == dma_pkg::ADDR_INSTR_DATA);
    assign running = (state_reg != dma_pkg::ST_IDLE);

    // Off-chip writes wait while the processor owns the bus
    assign bus_ok = xram_grant && !(xram_offchip && cfg_reg[dma_pkg::CFG_HALT]);

    // Buffers drain through the FIFO; a full FIFO stalls buffer hand-off
    assign ff_in_valid = running && ((full0_reg && !need0_reg) || (full1_reg && !need1_reg));
    assign ff_in_data  = (full0_reg && !need0_reg) ? buf0_reg : buf1_reg;
    assign take0 = ff_in_valid && ff_in_ready && full0_reg && !need0_reg;
    assign take1 = ff_in_valid && ff_in_ready && !(full0_reg && !need0_reg);
    assign ff_out_ready = bus_ok;

    dma_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (ff_in_valid),
        .in_ready  (ff_in_ready),
        .in_data   (ff_in_data),
        .out_valid (ff_out_valid),
        .out_ready (ff_out_ready),
        .out_data  (ff_out_data)
    );

    // Event detection per ADC
    assign ev_warn0 = running && adc0_done && full0_reg;
    assign ev_warn1 = running && adc1_done && full1_reg;
    assign ev_err0  = ev_warn0 && pend0_reg;
    assign ev_err1  = ev_warn1 && pend1_reg;

    // Per-ADC double buffer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            full0_reg <= 1'b0;
            full1_reg <= 1'b0;
            pend0_reg <= 1'b0;
            pend1_reg <= 1'b0;
            buf0_reg  <= '0;
            buf1_reg  <= '0;
            hold0_reg <= '0;
            hold1_reg <= '0;
        end else begin
            if (adc0_done) begin
                hold0_reg <= adc0_data;
            end
            if (adc1_done) begin
                hold1_reg <= adc1_data;
            end
            if (take0) begin
                full0_reg <= 1'b0;
            end
            if (take1) begin
                full1_reg <= 1'b0;
            end
            if (running && adc0_done && need0_reg && (!full0_reg || take0)) begin
                buf0_reg  <= adc0_data;
                full0_reg <= 1'b1;
            end else if (running && adc0_done && full0_reg && !take0) begin
                pend0_reg <= 1'b1;
            end else if (pend0_reg && !full0_reg) begin
                buf0_reg  <= hold0_reg;
                full0_reg <= 1'b1;
                pend0_reg <= 1'b0;
            end
            if (running && adc1_done && need1_reg && (!full1_reg || take1)) begin
                buf1_reg  <= adc1_data;
                full1_reg <= 1'b1;
            end else if (running && adc1_done && full1_reg && !take1) begin
                pend1_reg <= 1'b1;
            end else if (pend1_reg && !full1_reg) begin
                buf1_reg  <= hold1_reg;
                full1_reg <= 1'b1;
                pend1_reg <= 1'b0;
            end
            if (!running) begin
                pend0_reg <= 1'b0;
                pend1_reg <= 1'b0;
            end
        end
    end

    // XRAM write port
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xram_wr    <= 1'b0;
            xram_addr  <= '0;
            xram_wdata <= '0;
            wptr_reg   <= '0;
        end else begin
            xram_wr <= ff_out_valid && ff_out_ready;
            if (ff_out_valid && ff_out_ready) begin
                xram_addr  <= wptr_reg;
                xram_wdata <= ff_out_data;
                wptr_reg   <= wptr_reg + dma_pkg::ADDR_STEP;
            end
            if (wr_ctl && reg_wdata[dma_pkg::CTL_RUN] && !running) begin
                wptr_reg <= xram_base;
            end
        end
    end

    // Instruction buffer and auto-incrementing address
    always_ff @(posedge clk_sys) begin
        if (acc_idt && reg_wr) begin
            ibuf[iaddr_reg] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            iaddr_reg <= dma_pkg::RESET_INSTR_ADDR;
        end else if (reg_wr && reg_addr == dma_pkg::ADDR_INSTR_ADDR) begin
            iaddr_reg <= reg_wdata[5:0];
        end else if (acc_idt) begin
            iaddr_reg <= iaddr_reg + 6'h01;
        end
    end

    // Instruction sequencer
    assign instr_end = (state_reg == dma_pkg::ST_WAIT) && !need0_reg && !need1_reg
                       && !full0_reg && !full1_reg && !pend0_reg && !pend1_reg;

    always_ff @(posedge clk_sys) begin
        ev_done <= 1'b0;
        ev_eop  <= 1'b0;
        ev_rep  <= 1'b0;
        if (reset) begin
            state_reg <= dma_pkg::ST_IDLE;
            pc_reg    <= '0;
            ins_reg   <= '0;
            rep_reg   <= dma_pkg::RESET_REPEAT;
            need0_reg <= 1'b0;
            need1_reg <= 1'b0;
        end else if (wr_ctl && !reg_wdata[dma_pkg::CTL_RUN]) begin
            state_reg <= dma_pkg::ST_IDLE;
            need0_reg <= 1'b0;
            need1_reg <= 1'b0;
        end else begin
            if (adc0_done && running) begin
                need0_reg <= 1'b0;
            end
            if (adc1_done && running) begin
                need1_reg <= 1'b0;
            end
            case (state_reg)
                dma_pkg::ST_IDLE: begin
                    if (wr_ctl && reg_wdata[dma_pkg::CTL_RUN]) begin
                        state_reg <= dma_pkg::ST_FETCH;
                        pc_reg    <= instr_boundary;
                        rep_reg   <= repeat_limit;
                    end
                end
                dma_pkg::ST_FETCH: begin
                    ins_reg <= ibuf[pc_reg];
                    if (is_eop(ibuf[pc_reg])) begin
                        ev_eop <= 1'b1;
                        pc_reg <= instr_boundary;
                        if (ibuf[pc_reg][dma_pkg::INS_CONT]) begin
                            state_reg <= dma_pkg::ST_FETCH;
                        end else if (!ctl_reg[dma_pkg::CTL_MODE]) begin
                            rep_reg <= rep_reg - 16'h0001;
                            if (rep_reg == 16'h0001 || rep_reg == 16'h0000) begin
                                ev_rep    <= 1'b1;
                                ev_done   <= 1'b1;
                                state_reg <= dma_pkg::ST_IDLE;
                            end
                        end else begin
                            ev_done   <= 1'b1;
                            state_reg <= dma_pkg::ST_IDLE;
                        end
                    end else begin
                        // Differential result rides the first ADC's path
                        need0_reg <= ibuf[pc_reg][dma_pkg::INS_ADC0]
                                     | ibuf[pc_reg][dma_pkg::INS_DIFF];
                        need1_reg <= ibuf[pc_reg][dma_pkg::INS_ADC1];
                        state_reg <= dma_pkg::ST_WAIT;
                    end
                end
                dma_pkg::ST_WAIT: begin
                    if (instr_end) begin
                        state_reg <= dma_pkg::ST_FETCH;
                        if (ctl_reg[dma_pkg::CTL_MODE]) begin
                            rep_reg <= rep_reg - 16'h0001;
                            if (rep_reg == 16'h0001 || rep_reg == 16'h0000) begin
                                ev_rep  <= 1'b1;
                                rep_reg <= repeat_limit;
                                pc_reg  <= pc_reg + 6'h01;
                            end
                        end else begin
                            pc_reg <= pc_reg + 6'h01;
                        end
                    end
                end
                default: state_reg <= dma_pkg::ST_IDLE;
            endcase
        end
    end

    // Control register: set beats software clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl_reg <= dma_pkg::RESET_CONTROL;
        end else begin
            if (wr_ctl) begin
                ctl_reg[dma_pkg::CTL_MODE]    <= reg_wdata[dma_pkg::CTL_MODE];
                ctl_reg[dma_pkg::CTL_WARN_EN] <= reg_wdata[dma_pkg::CTL_WARN_EN];
            end
            ctl_reg[dma_pkg::CTL_RUN] <= 1'b0;
            ctl_reg[dma_pkg::CTL_DONE] <= ev_done
                | (ctl_reg[dma_pkg::CTL_DONE] & !(wr_ctl & !reg_wdata[dma_pkg::CTL_DONE]));
            ctl_reg[dma_pkg::CTL_ERR1] <= ev_err1
                | (ctl_reg[dma_pkg::CTL_ERR1] & !(wr_ctl & !reg_wdata[dma_pkg::CTL_ERR1]));
            ctl_reg[dma_pkg::CTL_ERR0] <= ev_err0
                | (ctl_reg[dma_pkg::CTL_ERR0] & !(wr_ctl & !reg_wdata[dma_pkg::CTL_ERR0]));
            ctl_reg[dma_pkg::CTL_WARN1] <= ev_warn1
                | (ctl_reg[dma_pkg::CTL_WARN1] & !(wr_ctl & !reg_wdata[dma_pkg::CTL_WARN1]));
            ctl_reg[dma_pkg::CTL_WARN0] <= ev_warn0
                | (ctl_reg[dma_pkg::CTL_WARN0] & !(wr_ctl & !reg_wdata[dma_pkg::CTL_WARN0]));
        end
    end

    // Configuration register; busy bit mirrors off-chip activity
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_reg <= dma_pkg::RESET_CONFIG;
        end else begin
            if (wr_cfg) begin
                cfg_reg[dma_pkg::CFG_HALT]   <= reg_wdata[dma_pkg::CFG_HALT];
                cfg_reg[dma_pkg::CFG_REP_EN] <= reg_wdata[dma_pkg::CFG_REP_EN];
                cfg_reg[dma_pkg::CFG_EOP_EN] <= reg_wdata[dma_pkg::CFG_EOP_EN];
            end
            cfg_reg[dma_pkg::CFG_BUSY] <= xram_offchip && ff_out_valid && ff_out_ready;
            cfg_reg[5:4] <= 2'b00;
            cfg_reg[dma_pkg::CFG_REP_FLAG] <= ev_rep
                | (cfg_reg[dma_pkg::CFG_REP_FLAG] & !(wr_cfg & !reg_wdata[dma_pkg::CFG_REP_FLAG]));
            cfg_reg[dma_pkg::CFG_EOP_FLAG] <= ev_eop
                | (cfg_reg[dma_pkg::CFG_EOP_FLAG] & !(wr_cfg & !reg_wdata[dma_pkg::CFG_EOP_FLAG]));
        end
    end

    // Read mux; run bit reads back the sequencer's activity
    always_comb begin
        case (reg_addr)
            dma_pkg::ADDR_CONTROL:    reg_rdata = {running, ctl_reg[6:0]};
            dma_pkg::ADDR_CONFIG:     reg_rdata = cfg_reg;
            dma_pkg::ADDR_INSTR_ADDR: reg_rdata = {2'b00, iaddr_reg};
            dma_pkg::ADDR_INSTR_DATA: reg_rdata = ibuf[iaddr_reg];
            default:                  reg_rdata = 8'h00;
        endcase
    end

    // Single interrupt request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dma_irq <= 1'b0;
        end else begin
            dma_irq <= ctl_reg[dma_pkg::CTL_DONE] | ctl_reg[dma_pkg::CTL_ERR1]
                | ctl_reg[dma_pkg::CTL_ERR0]
                | (ctl_reg[dma_pkg::CTL_WARN_EN]
                   & (ctl_reg[dma_pkg::CTL_WARN1] | ctl_reg[dma_pkg::CTL_WARN0]))
                | (cfg_reg[dma_pkg::CFG_REP_EN] & cfg_reg[dma_pkg::CFG_REP_FLAG])
                | (cfg_reg[dma_pkg::CFG_EOP_EN] & cfg_reg[dma_pkg::CFG_EOP_FLAG]);
        end
    end
endmodule // adc_xram_dma

// File: dma_pkg.sv
// Package: register map, field positions and states of the ADC-to-XRAM DMA
package dma_pkg;
    localparam logic [7:0] ADDR_CONTROL     = 8'hD8;
    localparam logic [7:0] ADDR_INSTR_ADDR  = 8'hDD;
    localparam logic [7:0] ADDR_CONFIG      = 8'hDE;
    localparam logic [7:0] ADDR_INSTR_DATA  = 8'hDF;
    localparam logic [7:0] RESET_CONTROL    = 8'h00;
    localparam logic [7:0] RESET_CONFIG     = 8'h00;
    localparam logic [5:0] RESET_INSTR_ADDR = 6'h00;
    localparam logic [15:0] RESET_REPEAT    = 16'h0001;
    // dma_control fields
    localparam int CTL_RUN      = 7;
    localparam int CTL_DONE     = 6;
    localparam int CTL_MODE     = 5;
    localparam int CTL_ERR1     = 4;
    localparam int CTL_ERR0     = 3;
    localparam int CTL_WARN_EN  = 2;
    localparam int CTL_WARN1    = 1;
    localparam int CTL_WARN0    = 0;
    // dma_configuration fields
    localparam int CFG_HALT     = 7;
    localparam int CFG_BUSY     = 6;
    localparam int CFG_REP_EN   = 3;
    localparam int CFG_REP_FLAG = 2;
    localparam int CFG_EOP_EN   = 1;
    localparam int CFG_EOP_FLAG = 0;
    // Instruction word fields
    localparam int INS_CONT     = 7;
    localparam int INS_DIFF     = 6;
    localparam int INS_ADC1     = 5;
    localparam int INS_ADC0     = 4;
    localparam int INSTR_DEPTH  = 64;
    localparam int FIFO_DEPTH   = 4;
    localparam logic [15:0] ADDR_STEP = 16'h0002;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b10
    } seq_state_t;
endpackage

// File: dma_fifo.sv
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // dma_fifo

// File: adc_xram_dma_assertions.sv
// Checker: port-level properties of the ADC-to-XRAM DMA
`timescale 1ns/1ps
module adc_xram_dma_chk #(
    parameter int DATA_W = 16,
    parameter int FIFO_D = 4
) (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        xram_offchip,
    input wire logic        xram_grant,
    input wire logic        xram_wr,
    input wire logic [15:0] xram_addr,
    input wire logic        dma_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [5:0]  iaddr_reg;
    logic        halt_reg;
    logic        seen_reg;
    logic [15:0] last_reg;
    wire         ctl_rd = reg_addr == dma_pkg::ADDR_CONTROL;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            iaddr_reg <= 6'h00;
        end else if (reg_wr && reg_addr == dma_pkg::ADDR_INSTR_ADDR) begin
            iaddr_reg <= reg_wdata[5:0];
        end else if ((reg_wr || reg_rd) && reg_addr == dma_pkg::ADDR_INSTR_DATA) begin
            iaddr_reg <= iaddr_reg + 6'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            halt_reg <= 1'b0;
        end else if (reg_wr && reg_addr == dma_pkg::ADDR_CONFIG) begin
            halt_reg <= reg_wdata[dma_pkg::CFG_HALT];
        end
    end
    // Any control write with the run bit set restarts the chain check, also in mid-run
    always_ff @(posedge clk_sys) begin
        if (reset || (reg_wr && ctl_rd && reg_wdata[dma_pkg::CTL_RUN])) begin
            seen_reg <= 1'b0;
        end else if (xram_wr) begin
            seen_reg <= 1'b1;
            last_reg <= xram_addr;
        end
    end
    property p_grant; xram_wr |-> $past(xram_grant); endproperty
    a_grant: assert property (p_grant) else $error("write without grant");
    property p_halt; xram_wr |-> !($past(xram_offchip) && $past(halt_reg)); endproperty
    a_halt: assert property (p_halt) else $error("off-chip write while halted");
    property p_step; xram_wr && seen_reg |-> xram_addr == last_reg + 16'h0002; endproperty
    a_step: assert property (p_step) else $error("address step wrong");
    property p_iaddr;
        reg_addr == dma_pkg::ADDR_INSTR_ADDR |-> reg_rdata[5:0] == iaddr_reg;
    endproperty
    a_iaddr: assert property (p_iaddr) else $error("instruction address wrong");
    property p_sticky(int b);
        ctl_rd && $past(ctl_rd) && !$past(reg_wr) && $past(reg_rdata[b]) |-> reg_rdata[b];
    endproperty
    property p_err; p_sticky(dma_pkg::CTL_ERR0); endproperty
    a_err: assert property (p_err) else $error("error fell");
    property p_warn; p_sticky(dma_pkg::CTL_WARN0); endproperty
    a_warn: assert property (p_warn) else $error("warn fell");
    property p_done; p_sticky(dma_pkg::CTL_DONE); endproperty
    a_done: assert property (p_done) else $error("done fell");
    property p_irq; ctl_rd && reg_rdata[dma_pkg::CTL_ERR0] |-> ##[0:1] dma_irq; endproperty
    a_irq: assert property (p_irq) else $error("error without interrupt");
    property p_stop;
        reg_wr && ctl_rd && !reg_wdata[dma_pkg::CTL_RUN] ##1 ctl_rd |-> !reg_rdata[7];
    endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    c_wr: cover property (xram_wr);
    c_irq: cover property (dma_irq);
    c_err: cover property (ctl_rd && reg_rdata[dma_pkg::CTL_ERR0]);
endmodule // adc_xram_dma_chk
bind adc_xram_dma adc_xram_dma_chk #(.DATA_W(DATA_W), .FIFO_D(FIFO_D)) u_chk (.clk_sys,
    .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .xram_offchip,
    .xram_grant, .xram_wr, .xram_addr, .dma_irq);

// File: adc_xram_model.sv
// Partner model: two converters and the XRAM data memory
`timescale 1ns/1ps
module adc_xram_model (
    input  wire logic        clk_sys,
    input  wire logic        xram_wr,
    input  wire logic [15:0] xram_addr,
    input  wire logic [15:0] xram_wdata,
    output logic             adc0_done,
    output logic      [15:0] adc0_data,
    output logic             adc1_done,
    output logic      [15:0] adc1_data,
    output logic             xram_grant
);
    logic        stall = 1'b0;
    logic        slow  = 1'b0;
    logic        phase = 1'b0;
    logic [15:0] wa[$];
    logic [15:0] wd[$];
    // Slow mode grants every other cycle only
    assign xram_grant = !stall && (!slow || phase);
    initial begin
        adc0_done = 1'b0;
        adc1_done = 1'b0;
        adc0_data = 16'h0000;
        adc1_data = 16'h0000;
    end
    always @(posedge clk_sys) begin
        phase <= !phase;
        if (xram_wr) begin
            wa.push_back(xram_addr);
            wd.push_back(xram_wdata);
        end
    end
    // Data is inverted outside the pulse so a late sample is caught
    task automatic conv(input logic ch, input logic [15:0] v);
        @(posedge clk_sys) #1;
        if (ch) begin
            adc1_done = 1'b1;
            adc1_data = v;
        end else begin
            adc0_done = 1'b1;
            adc0_data = v;
        end
        @(posedge clk_sys) #1;
        adc0_done = 1'b0;
        adc1_done = 1'b0;
        adc0_data = ~adc0_data;
        adc1_data = ~adc1_data;
    endtask
endmodule // adc_xram_model

// File: tb.sv
// Testbench: register access, transfers and overflow of the DMA
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        offchip = 1'b0;
    logic        adc0_done, adc1_done, grant, xram_wr, dma_irq;
    logic [15:0] adc0_data, adc1_data, xram_addr, xram_wdata;
    int          fail_count = 0;
    int          n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    adc_xram_dma u_dut (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .instr_boundary(6'h00), .xram_base(16'h1000), .repeat_limit(16'h0001),
        .adc0_done, .adc0_data, .adc1_done, .adc1_data, .diff_mode(1'b0),
        .xram_offchip(offchip), .xram_grant(grant), .xram_wr, .xram_addr, .xram_wdata,
        .dma_irq);
    adc_xram_model u_adc (.clk_sys, .xram_wr, .xram_addr, .xram_wdata, .adc0_done,
        .adc0_data, .adc1_done, .adc1_data, .xram_grant(grant));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        #4 d = reg_rdata;
        @(posedge clk_sys) #1;
        reg_rd = 1'b0;
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 reset = 1'b0;
        rdc(dma_pkg::ADDR_CONTROL, 8'h00);
        rdc(dma_pkg::ADDR_CONFIG, 8'h00);
        rdc(8'hD9, 8'h00);
        wr(dma_pkg::ADDR_INSTR_ADDR, 8'h3F);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h10);
        rdc(dma_pkg::ADDR_INSTR_ADDR, 8'h00);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h50);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h30);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h00);
        wr(dma_pkg::ADDR_INSTR_ADDR, 8'h01);
        rdc(dma_pkg::ADDR_INSTR_DATA, 8'h30);
        rdc(dma_pkg::ADDR_INSTR_ADDR, 8'h02);
        wr(dma_pkg::ADDR_CONFIG, 8'h02);
        wr(dma_pkg::ADDR_CONTROL, 8'h80);
        repeat (10) @(posedge clk_sys);
        u_adc.conv(1'b0, 16'hA5C3);
        repeat (10) @(posedge clk_sys);
        u_adc.conv(1'b0, 16'h1234);
        repeat (10) @(posedge clk_sys);
        u_adc.conv(1'b1, 16'hBEEF);
        repeat (30) @(posedge clk_sys);
        chk(16'(u_adc.wd.size()), 16'h0003);
        chk(u_adc.wa[0], 16'h1000);
        chk(u_adc.wd[0], 16'hA5C3);
        chk(u_adc.wa[2], 16'h1004);
        chk(u_adc.wd[1], 16'h1234);
        chk(u_adc.wd[2], 16'hBEEF);
        rdc(dma_pkg::ADDR_CONTROL, 8'h40);
        rdc(dma_pkg::ADDR_CONFIG, 8'h07);
        chk({15'h0000, dma_irq}, 16'h0001);
        wr(dma_pkg::ADDR_CONTROL, 8'h00);
        wr(dma_pkg::ADDR_CONFIG, 8'h00);
        rdc(dma_pkg::ADDR_CONFIG, 8'h00);
        chk({15'h0000, dma_irq}, 16'h0000);
        u_adc.wa.delete();
        u_adc.wd.delete();
        wr(dma_pkg::ADDR_INSTR_ADDR, 8'h00);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h10);
        wr(dma_pkg::ADDR_INSTR_DATA, 8'h80);
        offchip = 1'b1;
        u_adc.stall = 1'b1;
        wr(dma_pkg::ADDR_CONTROL, 8'hA4);
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge clk_sys);
            u_adc.conv(1'b0, 16'h1110 + 16'(i));
        end
        rdc(dma_pkg::ADDR_CONTROL, 8'hAD);
        rdc(dma_pkg::ADDR_CONFIG, 8'h05);
        wr(dma_pkg::ADDR_CONFIG, 8'h80);
        u_adc.stall = 1'b0;
        u_adc.slow = 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(16'(u_adc.wd.size()), 16'h0000);
        wr(dma_pkg::ADDR_CONFIG, 8'h00);
        repeat (60) @(posedge clk_sys);
        chk(16'(u_adc.wd.size()), 16'h0006);
        chk(u_adc.wa[0], 16'h1000);
        chk(u_adc.wd[0], 16'h1110);
        chk(u_adc.wd[5], 16'h1117);
        wr(dma_pkg::ADDR_CONTROL, 8'h00);
        rdc(dma_pkg::ADDR_CONTROL, 8'h00);
        results();
    end
endmodule // tb
